//--- include/ovc_pkg.sv
// Package with register map, field layout, reset values and timing for output volume control
`default_nettype none
package ovc_pkg;
  localparam int OVC_ADDR_W = 8;
  localparam int OVC_DATA_W = 16;
  localparam int OVC_GAIN_W = 6;
  localparam int OVC_CHANNELS = 4;
  // Register offsets
  localparam logic [7:0] OVC_PHONES_LEFT_LEVEL = 8'h39;
  localparam logic [7:0] OVC_PHONES_RIGHT_LEVEL = 8'h3a;
  localparam logic [7:0] OVC_LINE_LEFT_LEVEL = 8'h3b;
  localparam logic [7:0] OVC_LINE_RIGHT_LEVEL = 8'h3c;
  localparam logic [7:0] OVC_TIMEOUT_CTRL = 8'h3d;
  // Field positions
  localparam int OVC_SILENCE_BIT = 8;
  localparam int OVC_COMMIT_BIT = 7;
  localparam int OVC_ZERO_GATE_BIT = 6;
  localparam int OVC_GAIN_LSB = 0;
  localparam int OVC_TIMEOUT_EN_BIT = 0;
  // Reset values
  localparam logic [5:0] OVC_PHONES_GAIN_RST = 6'h2d;
  localparam logic [5:0] OVC_LINE_GAIN_RST = 6'h39;
  localparam logic [5:0] OVC_GAIN_0DB = 6'h39;
  // Zero-cross timeout
  localparam int OVC_CLK_HZ = 20_000_000;
  localparam int OVC_TIMEOUT_MS = 10;
  localparam int OVC_TIMEOUT_CYC = OVC_CLK_HZ / 1000 * OVC_TIMEOUT_MS;
endpackage : ovc_pkg
`default_nettype wire

//--- hw/ovc_channel.sv
// One output channel: pending gain, zero-cross wait and timeout
`timescale 1ns/100ps
`default_nettype none
module ovc_channel
  import ovc_pkg::*;
#(
  parameter int GAIN_W = OVC_GAIN_W,
  parameter int TIMEOUT_CYC = OVC_TIMEOUT_CYC
) (
  input wire logic sys_clk_in, // System clock
  input wire logic srst_in, // Synchronous reset
  input wire logic [GAIN_W-1:0] rst_gain_in, // Reset gain code
  input wire logic commit_in, // Transfer stored gain
  input wire logic [GAIN_W-1:0] stored_gain_in, // Stored gain code
  input wire logic zero_gate_in, // Zero-cross gating enable
  input wire logic timeout_en_in, // Timeout enable
  input wire logic sample_en_in, // Sample strobe
  input wire logic zero_cross_in, // Zero crossing seen this sample
  output logic [GAIN_W-1:0] gain_out, // Active gain
  output logic pending_out // Change waiting
);
  localparam int CNT_W = $clog2(TIMEOUT_CYC + 1);

  // Refuse sizes the timeout counter and gain path cannot serve
  if (TIMEOUT_CYC < 1 || GAIN_W < 1) begin : g_bad_param
    $error("ovc_channel: bad parameters");
  end

  typedef struct packed {
    logic [GAIN_W-1:0] active;
    logic [GAIN_W-1:0] target;
    logic pending;
    logic [CNT_W-1:0] cnt;
  } ovc_ch_state_t;

  ovc_ch_state_t st_q;
  ovc_ch_state_t st_d;

  always_comb begin
    st_d = st_q;
    if (st_q.pending) begin
      if (timeout_en_in && st_q.cnt != CNT_W'(TIMEOUT_CYC)) begin
        st_d.cnt = st_q.cnt + CNT_W'(1);
      end
      if (sample_en_in && (!zero_gate_in || zero_cross_in)) begin // [R2] [R17]
        st_d.active = st_q.target;
        st_d.pending = 1'b0;
      end else if (timeout_en_in && st_q.cnt == CNT_W'(TIMEOUT_CYC)) begin // [R3] [R4]
        st_d.active = st_q.target;
        st_d.pending = 1'b0;
      end
    end
    if (commit_in) begin // [R6] [R7]
      st_d.target = stored_gain_in;
      st_d.pending = 1'b1;
      st_d.cnt = '0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      st_q.active <= rst_gain_in;
      st_q.target <= rst_gain_in;
      st_q.pending <= 1'b0;
      st_q.cnt <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign gain_out = st_q.active;
  assign pending_out = st_q.pending;
endmodule : ovc_channel
`default_nettype wire

//--- hw/ovc_top.sv
// Output volume control register bank for headphone and line pairs
// What this block does
// [R1] Each output channel has its own mute, zero-cross enable and gain, independent of the others.
// [R2] With zero-cross enabled a new gain waits for the channel's signal to cross zero.
// [R3] A pending gain is applied when the zero-cross timeout expires.
// [R4] The timeout runs only when the timeout enable bit is set, otherwise the wait is unbounded.
// [R5] Writing a gain with the update bit clear only stores it; the active gain stays.
// [R6] Writing one to bit 7 of either headphone register commits both headphone gains together.
// [R7] Writing one to bit 7 of either line register commits both line gains together.
// [R8] Bit 7 is a write-only strobe, never stored.
// [R9] Bit 8 of a headphone register mutes that channel, resetting to zero.
// [R10] Bit 8 of a line register mutes that channel, resetting to zero.
// [R11] Bit 6 of a headphone register enables zero-cross gating, resetting to zero.
// [R12] Bit 6 of a line register enables zero-cross gating, resetting to zero.
// [R13] Headphone gain codes run from -57dB at 0 in 1dB steps to 0dB at 0x39 and +6dB at 0x3f.
// [R14] Line gain codes use the same encoding.
// [R15] Headphone gains reset to 0x2d and line gains to 0x39.
// [R16] Reads return zero in bit 7 and the stored mute, zero-cross and gain elsewhere.
// [R17] Without zero-cross a commit takes effect at the next sample; each channel waits on its own crossing.
`timescale 1ns/100ps
`default_nettype none
module ovc_top
  import ovc_pkg::*;
#(
  parameter int TIMEOUT_CYC = OVC_TIMEOUT_CYC
) (
  input wire logic sys_clk_in, // System clock, 20 MHz
  input wire logic srst_in, // Synchronous reset
  input wire logic [OVC_ADDR_W-1:0] reg_addr_in, // Register address
  input wire logic [OVC_DATA_W-1:0] reg_wdata_in, // Write data
  input wire logic reg_wr_in, // Write strobe
  input wire logic reg_rd_in, // Read strobe
  output logic [OVC_DATA_W-1:0] reg_rdata_out, // Read data, cycle after strobe
  input wire logic sample_en_in, // Codec sample strobe
  input wire logic [OVC_CHANNELS-1:0] zero_cross_in, // Per-channel zero crossing
  output logic [OVC_GAIN_W-1:0] phones_left_gain_out, // Active headphone left gain
  output logic [OVC_GAIN_W-1:0] phones_right_gain_out, // Active headphone right gain
  output logic [OVC_GAIN_W-1:0] line_left_gain_out, // Active line left gain
  output logic [OVC_GAIN_W-1:0] line_right_gain_out, // Active line right gain
  output logic [OVC_CHANNELS-1:0] silence_out, // Mute per channel
  output logic [OVC_CHANNELS-1:0] pending_out // Change waiting per channel
);
  // Refuse a timeout the channel counters cannot serve
  if (TIMEOUT_CYC < 1) begin : g_bad_timeout
    $error("ovc_top: TIMEOUT_CYC must be positive");
  end

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [OVC_CHANNELS-1:0] silence;
    logic [OVC_CHANNELS-1:0] zero_gate;
    logic [OVC_CHANNELS-1:0][OVC_GAIN_W-1:0] stored;
    logic zero_wait_timeout_enable;
    logic [OVC_DATA_W-1:0] rdata;
    logic [OVC_CHANNELS-1:0] commit;
    logic [OVC_CHANNELS-1:0] gate_sync;
    logic sample;
    logic [OVC_CHANNELS-1:0] zc;
    logic [OVC_CHANNELS-1:0][OVC_GAIN_W-1:0] gain;
    logic [OVC_CHANNELS-1:0] waiting;
  } ovc_state_t;

  ovc_state_t st_q;
  ovc_state_t st_d;
  logic [OVC_CHANNELS-1:0][OVC_GAIN_W-1:0] active;
  logic [OVC_CHANNELS-1:0] pend;
  logic [OVC_CHANNELS-1:0][OVC_GAIN_W-1:0] rst_gain;
  logic [1:0] hit;

  assign rst_gain[0] = OVC_PHONES_GAIN_RST; // [R15]
  assign rst_gain[1] = OVC_PHONES_GAIN_RST;
  assign rst_gain[2] = OVC_LINE_GAIN_RST;
  assign rst_gain[3] = OVC_LINE_GAIN_RST;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode
  always_comb begin
    int idx;
    idx = 0;
    hit = 2'b00;
    st_d = st_q;
    st_d.commit = '0;
    st_d.rdata = '0;
    st_d.sample = sample_en_in;
    st_d.zc = zero_cross_in;
    st_d.gate_sync = st_q.zero_gate;
    st_d.gain = active;
    st_d.waiting = pend;
    if (reg_addr_in >= OVC_PHONES_LEFT_LEVEL && reg_addr_in <= OVC_LINE_RIGHT_LEVEL) begin
      hit = 2'b01;
      idx = int'(reg_addr_in - OVC_PHONES_LEFT_LEVEL);
    end else if (reg_addr_in == OVC_TIMEOUT_CTRL) begin
      hit = 2'b10;
    end
    if (reg_wr_in) begin
      if (hit == 2'b01) begin
        st_d.silence[idx] = reg_wdata_in[OVC_SILENCE_BIT]; // [R1] [R9] [R10]
        st_d.zero_gate[idx] = reg_wdata_in[OVC_ZERO_GATE_BIT]; // [R11] [R12]
        st_d.stored[idx] = reg_wdata_in[OVC_GAIN_LSB +: OVC_GAIN_W]; // [R5] [R13] [R14]
        if (reg_wdata_in[OVC_COMMIT_BIT]) begin // [R8]
          if (idx < 2) begin
            st_d.commit[1:0] = 2'b11; // [R6]
          end else begin
            st_d.commit[3:2] = 2'b11; // [R7]
          end
        end
      end else if (hit == 2'b10) begin
        st_d.zero_wait_timeout_enable = reg_wdata_in[OVC_TIMEOUT_EN_BIT]; // [R4]
      end
    end
    if (reg_rd_in) begin
      if (hit == 2'b01) begin
        st_d.rdata[OVC_SILENCE_BIT] = st_q.silence[idx]; // [R16]
        st_d.rdata[OVC_ZERO_GATE_BIT] = st_q.zero_gate[idx];
        st_d.rdata[OVC_GAIN_LSB +: OVC_GAIN_W] = st_q.stored[idx];
      end else if (hit == 2'b10) begin
        st_d.rdata[OVC_TIMEOUT_EN_BIT] = st_q.zero_wait_timeout_enable;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      st_q.silence <= '0;
      st_q.zero_gate <= '0;
      st_q.stored[0] <= OVC_PHONES_GAIN_RST;
      st_q.stored[1] <= OVC_PHONES_GAIN_RST;
      st_q.stored[2] <= OVC_LINE_GAIN_RST;
      st_q.stored[3] <= OVC_LINE_GAIN_RST;
      st_q.zero_wait_timeout_enable <= 1'b0;
      st_q.rdata <= '0;
      st_q.commit <= '0;
      st_q.gate_sync <= '0;
      st_q.sample <= 1'b0;
      st_q.zc <= '0;
      st_q.gain <= rst_gain; // [R15]
      st_q.waiting <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel gain staging
  for (genvar ch = 0; ch < OVC_CHANNELS; ch++) begin : g_ch
    ovc_channel #(
      .GAIN_W(OVC_GAIN_W),
      .TIMEOUT_CYC(TIMEOUT_CYC)
    ) u_ch (
      .sys_clk_in(sys_clk_in),
      .srst_in(srst_in),
      .rst_gain_in(rst_gain[ch]),
      .commit_in(st_q.commit[ch]),
      .stored_gain_in(st_q.stored[ch]),
      .zero_gate_in(st_q.gate_sync[ch]),
      .timeout_en_in(st_q.zero_wait_timeout_enable),
      .sample_en_in(st_q.sample),
      .zero_cross_in(st_q.zc[ch]),
      .gain_out(active[ch]),
      .pending_out(pend[ch])
    );
  end

  // Outputs straight from flip-flops
  assign reg_rdata_out = st_q.rdata;
  assign phones_left_gain_out = st_q.gain[0];
  assign phones_right_gain_out = st_q.gain[1];
  assign line_left_gain_out = st_q.gain[2];
  assign line_right_gain_out = st_q.gain[3];
  assign silence_out = st_q.silence;
  assign pending_out = st_q.waiting;
endmodule : ovc_top
`default_nettype wire

//--- tb/ovc_top_checker.sv
// Port-level assertions for the output volume control block
`timescale 1ns/100ps
`default_nettype none
module ovc_top_checker
  import ovc_pkg::*;
#(
  parameter int TIMEOUT_CYC = OVC_TIMEOUT_CYC
) (
  input wire logic sys_clk_in, // Clock
  input wire logic srst_in, // Reset
  input wire logic [OVC_ADDR_W-1:0] reg_addr_in, // Address
  input wire logic [OVC_DATA_W-1:0] reg_wdata_in, // Write data
  input wire logic reg_wr_in, // Write strobe
  input wire logic reg_rd_in, // Read strobe
  input wire logic [OVC_DATA_W-1:0] reg_rdata_out, // Read data
  input wire logic sample_en_in, // Sample strobe
  input wire logic [OVC_CHANNELS-1:0] zero_cross_in, // Zero crossings
  input wire logic [OVC_GAIN_W-1:0] phones_left_gain_out, // Gain
  input wire logic [OVC_GAIN_W-1:0] phones_right_gain_out, // Gain
  input wire logic [OVC_GAIN_W-1:0] line_left_gain_out, // Gain
  input wire logic [OVC_GAIN_W-1:0] line_right_gain_out, // Gain
  input wire logic [OVC_CHANNELS-1:0] silence_out, // Mutes
  input wire logic [OVC_CHANNELS-1:0] pending_out // Waiting changes
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  AST_RST_GAINS: assert property ($past(srst_in) |->
    phones_left_gain_out == OVC_PHONES_GAIN_RST && phones_right_gain_out == OVC_PHONES_GAIN_RST
    && line_left_gain_out == OVC_LINE_GAIN_RST && line_right_gain_out == OVC_LINE_GAIN_RST)
    else $error("gain not at reset code");
  AST_BIT7_ZERO: assert property (reg_rdata_out[OVC_COMMIT_BIT] == 1'b0)
    else $error("update bit read back as one");
  AST_RD_IDLE: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 16'h0000)
    else $error("read data outside read cycle");
  AST_HP_SILENCE: assert property (reg_wr_in && reg_addr_in == OVC_PHONES_LEFT_LEVEL |=>
    silence_out[0] == $past(reg_wdata_in[OVC_SILENCE_BIT])) else $error("left phones mute wrong");
  AST_LINE_SILENCE: assert property (reg_wr_in && reg_addr_in == OVC_LINE_LEFT_LEVEL |=>
    silence_out[2] == $past(reg_wdata_in[OVC_SILENCE_BIT])) else $error("left line mute wrong");
  AST_HP_ISOLATE: assert property (reg_wr_in && reg_addr_in == OVC_PHONES_LEFT_LEVEL |=>
    silence_out[3:1] == $past(silence_out[3:1])) else $error("write to one channel moved another mute");
  AST_GAIN_CAUSE: assert property ($changed(phones_left_gain_out) |-> $fell(pending_out[0]))
    else $error("gain moved without pending change");
  AST_HP_PAIR: assert property (reg_wr_in && reg_addr_in == OVC_PHONES_RIGHT_LEVEL &&
    reg_wdata_in[OVC_COMMIT_BIT] |-> ##[1:3] pending_out[1:0] == 2'b11) else $error("phones pair not committed");
  AST_LINE_PAIR: assert property (reg_wr_in && reg_addr_in == OVC_LINE_RIGHT_LEVEL &&
    reg_wdata_in[OVC_COMMIT_BIT] |-> ##[1:3] pending_out[3:2] == 2'b11) else $error("line pair not committed");
endmodule : ovc_top_checker
bind ovc_top ovc_top_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .sample_en_in(sample_en_in), .zero_cross_in(zero_cross_in),
  .phones_left_gain_out(phones_left_gain_out), .phones_right_gain_out(phones_right_gain_out),
  .line_left_gain_out(line_left_gain_out), .line_right_gain_out(line_right_gain_out),
  .silence_out(silence_out), .pending_out(pending_out));
`default_nettype wire

//--- tb/ovc_top_tb_top.sv
// Register-level testbench for the output volume control block
`timescale 1ns/100ps
`default_nettype none
module ovc_top_tb_top
  import ovc_pkg::*;
;
  logic sys_clk_in, srst_in, reg_wr_in, reg_rd_in, sample_en_in;
  logic [7:0] reg_addr_in;
  logic [15:0] reg_wdata_in, reg_rdata_out;
  logic [3:0] zero_cross_in, silence_out, pending_out;
  logic [5:0] hl, hr, ll, lr;
  logic [23:0] gains;
  int failures = 0;
  int tests_run = 0;
  assign gains = {hl, hr, ll, lr};
  ovc_top #(.TIMEOUT_CYC(20)) u_dut (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .sample_en_in(sample_en_in), .zero_cross_in(zero_cross_in), .phones_left_gain_out(hl),
    .phones_right_gain_out(hr), .line_left_gain_out(ll), .line_right_gain_out(lr),
    .silence_out(silence_out), .pending_out(pending_out));
  initial begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    #1 chk({8'h00, reg_rdata_out}, {8'h00, exp});
  endtask : rd
  // One sample strobe with the given crossings, then let the gains settle
  task automatic smp(input logic [3:0] zc);
    @(posedge sys_clk_in);
    sample_en_in <= 1'b1;
    zero_cross_in <= zc;
    @(posedge sys_clk_in);
    sample_en_in <= 1'b0;
    zero_cross_in <= 4'h0;
    repeat (3) @(posedge sys_clk_in);
    #1;
  endtask : smp
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  initial begin
    repeat (3000) @(posedge sys_clk_in);
    failures++;
    stop_test();
  end
  initial begin
    srst_in = 1'b1;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    sample_en_in = 1'b0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 16'h0000;
    zero_cross_in = 4'h0;
    repeat (2) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    #1 chk(gains, {OVC_PHONES_GAIN_RST, OVC_PHONES_GAIN_RST, OVC_LINE_GAIN_RST, OVC_LINE_GAIN_RST});
    rd(OVC_PHONES_RIGHT_LEVEL, 16'h002d);
    rd(OVC_LINE_RIGHT_LEVEL, 16'h0039);
    rd(OVC_TIMEOUT_CTRL, 16'h0000);
    wr(OVC_PHONES_LEFT_LEVEL, 16'h0130);
    smp(4'hf);
    chk({16'h0000, silence_out, pending_out}, 24'h00_0010);
    chk(gains, {6'h2d, 6'h2d, 6'h39, 6'h39});
    rd(OVC_PHONES_LEFT_LEVEL, 16'h0130);
    wr(OVC_PHONES_RIGHT_LEVEL, 16'h00a5);
    smp(4'h0);
    chk(gains, {6'h30, 6'h25, 6'h39, 6'h39});
    rd(OVC_PHONES_RIGHT_LEVEL, 16'h0025);
    wr(OVC_LINE_LEFT_LEVEL, 16'h007f);
    wr(OVC_LINE_RIGHT_LEVEL, 16'h01c0);
    smp(4'b0100);
    chk(gains, {6'h30, 6'h25, 6'h3f, 6'h39});
    chk({16'h0000, silence_out, pending_out}, 24'h00_0098);
    smp(4'b1000);
    chk(gains, {6'h30, 6'h25, 6'h3f, 6'h00});
    rd(OVC_LINE_RIGHT_LEVEL, 16'h0140);
    wr(OVC_TIMEOUT_CTRL, 16'h0001);
    rd(OVC_TIMEOUT_CTRL, 16'h0001);
    wr(OVC_PHONES_LEFT_LEVEL, 16'h00c1);
    repeat (10) @(posedge sys_clk_in);
    #1 chk(gains, {6'h30, 6'h25, 6'h3f, 6'h00});
    chk({16'h0000, silence_out, pending_out}, 24'h00_0083);
    repeat (20) @(posedge sys_clk_in);
    #1 chk(gains, {6'h01, 6'h25, 6'h3f, 6'h00});
    chk({16'h0000, silence_out, pending_out}, 24'h00_0080);
    smp(4'h0);
    wr(OVC_TIMEOUT_CTRL, 16'h0000);
    wr(OVC_PHONES_LEFT_LEVEL, 16'h00c2);
    repeat (30) @(posedge sys_clk_in);
    #1 chk({16'h0000, silence_out, pending_out}, 24'h00_0083);
    smp(4'b0001);
    chk(gains, {6'h02, 6'h25, 6'h3f, 6'h00});
    wr(8'h3e, 16'h01ff);
    rd(8'h3e, 16'h0000);
    rd(8'h00, 16'h0000);
    rd(OVC_PHONES_LEFT_LEVEL, 16'h0042);
    // Reset again in mid-run: gains, mutes, pending flags and two level registers must return to their reset values
    @(posedge sys_clk_in);
    srst_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    #1 chk(gains, {OVC_PHONES_GAIN_RST, OVC_PHONES_GAIN_RST, OVC_LINE_GAIN_RST, OVC_LINE_GAIN_RST});
    chk({16'h0000, silence_out, pending_out}, 24'h00_0000);
    rd(OVC_PHONES_LEFT_LEVEL, 16'h002d);
    rd(OVC_LINE_RIGHT_LEVEL, 16'h0039);
    stop_test();
  end
endmodule : ovc_top_tb_top
`default_nettype wire
